// ---- src/etsr_shift.v ----
// Purpose: Edge-triggered eight-bit shift register with one selected bit output
// Assumes: All inputs synchronous to core_clk; one clock stands for one program cycle
// Notes:   rst_b models power-up; retain_en keeps contents through it
`default_nettype none
`include "etsr_regs.vh"
// Contract
// - Trigger rise samples data, shifts once
// - Trigger fall changes nothing
// - Direction 0: data into first, shift up
// - Direction 1: data into last, shift down
// - Four bytes of eight bits, indexed
// - Output follows configured byte and bit
// - No retention: restart empty after power loss
// - Retention keeps all bits, never partial
// - Configuration fixed while running
module etsr_shift #(
	parameter NUM_BYTES = `ETSR_NUM_BYTES,
	parameter IDX_W     = `ETSR_IDX_W
) (
	// Clock and reset
	input  wire             core_clk,
	input  wire             rst_b,
	// Configuration (zero-based byte index and bit position)
	input  wire [IDX_W-1:0] cfg_byte_idx,
	input  wire [`ETSR_BIT_W-1:0] cfg_bit_sel,
	input  wire             retain_en,
	// Logic inputs
	input  wire             shift_trig,
	input  wire             shift_dir,
	input  wire             data_in,
	// Output
	output reg              bit_out_reg
);
	reg                      trig_prev_reg;
	reg                      state_reg;
	reg  [IDX_W-1:0]         byte_idx_reg;
	reg  [`ETSR_BIT_W-1:0]   bit_sel_reg;
	reg  [IDX_W-1:0]         clr_idx_reg;
	reg                      pend_reg;
	reg                      pend_dir_reg;
	reg                      pend_data_reg;
	reg                      wr_en;
	reg  [IDX_W-1:0]         wr_idx;
	reg  [`ETSR_BYTE_W-1:0]  wr_data;
	wire [`ETSR_BYTE_W-1:0]  rd_data;
	wire                     trig_rise;
	reg  [`ETSR_BYTE_W-1:0]  shadow_reg;
	reg                      warm_reg;
	reg                      loaded_reg;

	function [`ETSR_BYTE_W-1:0] shift_byte;
		input [`ETSR_BYTE_W-1:0] cur;
		input                    dir;
		input                    din;
		begin
			if (dir == `ETSR_DIR_UP) begin
				shift_byte = {cur[`ETSR_BYTE_W-2:0], din};
			end else begin
				shift_byte = {din, cur[`ETSR_BYTE_W-1:1]};
			end
		end
	endfunction

	function pick_bit;
		input [`ETSR_BYTE_W-1:0] cur;
		input [`ETSR_BIT_W-1:0]  sel;
		begin
			pick_bit = cur[sel];
		end
	endfunction

	assign trig_rise = shift_trig & ~trig_prev_reg;

	// Shadow holds the active byte so a shift never waits on a memory read
	always @* begin
		wr_en   = 1'b0;
		wr_idx  = byte_idx_reg;
		wr_data = shift_byte(shadow_reg, pend_dir_reg, pend_data_reg);
		if (state_reg == `ETSR_ST_INIT) begin
			wr_en   = ~retain_en;
			wr_idx  = clr_idx_reg;
			wr_data = `ETSR_BYTE_CLEAR;
		end else if (pend_reg) begin
			wr_en = 1'b1;
		end
	end

	etsr_store #(
		.NUM_BYTES (NUM_BYTES),
		.IDX_W     (IDX_W)
	) u_store (
		.core_clk    (core_clk),
		.wr_en       (wr_en),
		.wr_idx      (wr_idx),
		.wr_data     (wr_data),
		.rd_idx      (byte_idx_reg),
		.rd_data_reg (rd_data)
	);

	// Edge history resets high so a level already up at release is no edge
	always @(posedge core_clk) begin
		if (!rst_b) begin
			trig_prev_reg <= 1'b1;
		end else begin
			trig_prev_reg <= shift_trig;
		end
	end

	// Start-of-run sweep over every byte, then the run state
	always @(posedge core_clk) begin
		if (!rst_b) begin
			state_reg   <= `ETSR_ST_INIT;
			clr_idx_reg <= {IDX_W{1'b0}};
		end else begin
			case (state_reg)
				`ETSR_ST_INIT: begin
					clr_idx_reg <= clr_idx_reg + {{(IDX_W-1){1'b0}}, 1'b1};
					// Sweep every byte so retention is all or nothing
					if (clr_idx_reg == NUM_BYTES - 1) begin
						state_reg <= `ETSR_ST_RUN;
					end
				end
				`ETSR_ST_RUN: begin
					state_reg <= `ETSR_ST_RUN;
				end
				default: begin
					state_reg <= `ETSR_ST_INIT;
				end
			endcase
		end
	end

	// Configuration is captured on every sweep cycle, then held
	always @(posedge core_clk) begin
		if (!rst_b) begin
			byte_idx_reg <= {IDX_W{1'b0}};
			bit_sel_reg  <= {`ETSR_BIT_W{1'b0}};
		end else if (state_reg == `ETSR_ST_INIT) begin
			byte_idx_reg <= cfg_byte_idx;
			bit_sel_reg  <= cfg_bit_sel;
		end
	end

	// Read data is trusted only one cycle into the run, once the last
	// sweep write has landed; triggers before then are not taken
	always @(posedge core_clk) begin
		if (!rst_b) begin
			warm_reg <= 1'b0;
		end else if (state_reg == `ETSR_ST_RUN) begin
			warm_reg <= 1'b1;
		end
	end

	// Pending shift: direction and data sampled on the edge cycle
	always @(posedge core_clk) begin
		if (!rst_b) begin
			pend_reg      <= 1'b0;
			pend_dir_reg  <= `ETSR_DIR_UP;
			pend_data_reg <= 1'b0;
		end else begin
			pend_reg      <= trig_rise & warm_reg;
			pend_dir_reg  <= shift_dir;
			pend_data_reg <= data_in;
		end
	end

	// Shadow is loaded once from memory, then kept by every write.
	// Re-reading memory after a write would show the old byte for a cycle.
	always @(posedge core_clk) begin
		if (!rst_b) begin
			loaded_reg  <= 1'b0;
			shadow_reg  <= `ETSR_BYTE_CLEAR;
			bit_out_reg <= 1'b0;
		end else if (pend_reg) begin
			shadow_reg  <= wr_data;
			bit_out_reg <= pick_bit(wr_data, bit_sel_reg);
		end else if (warm_reg && !loaded_reg) begin
			loaded_reg  <= 1'b1;
			shadow_reg  <= rd_data;
			bit_out_reg <= pick_bit(rd_data, bit_sel_reg);
		end else begin
			bit_out_reg <= pick_bit(shadow_reg, bit_sel_reg);
		end
	end
endmodule // etsr_shift
`default_nettype wire

// ---- src/etsr_regs.vh ----
// Purpose: Constants for the edge-triggered shift register block
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef ETSR_REGS_VH
`define ETSR_REGS_VH
`define ETSR_BYTE_W      8
`define ETSR_NUM_BYTES   4
`define ETSR_IDX_W       2
`define ETSR_BIT_W       3
`define ETSR_DIR_UP      1'h0
`define ETSR_DIR_DOWN    1'h1
`define ETSR_BYTE_CLEAR  8'h00
`define ETSR_ST_INIT     1'h0
`define ETSR_ST_RUN      1'h1
`endif

// ---- src/etsr_store.v ----
// Purpose: Storage for the shift register bytes, registered read port
// Assumes: One write per clock at most
// Notes:   Bytes are retained unless cleared by the owner
`default_nettype none
`include "etsr_regs.vh"
module etsr_store #(
	parameter NUM_BYTES = `ETSR_NUM_BYTES,
	parameter IDX_W     = `ETSR_IDX_W
) (
	// Clock
	input  wire                    core_clk,
	// Write port
	input  wire                    wr_en,
	input  wire [IDX_W-1:0]        wr_idx,
	input  wire [`ETSR_BYTE_W-1:0] wr_data,
	// Read port
	input  wire [IDX_W-1:0]        rd_idx,
	output reg  [`ETSR_BYTE_W-1:0] rd_data_reg
);
	reg [`ETSR_BYTE_W-1:0] mem [0:NUM_BYTES-1];

	// No reset here: retention is the owner's decision, not the memory's
	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		rd_data_reg <= mem[rd_idx];
	end
endmodule // etsr_store
`default_nettype wire

// ---- testbench/etsr_props.sv ----
// Purpose: Port checks for etsr_shift
// Assumes: One clock, sync low reset
// Notes: ok masks the init sweep
`default_nettype none
module etsr_props #(parameter NUM_BYTES = 4, IDX_W = 2) (
	input wire logic core_clk, rst_b, retain_en, shift_trig, shift_dir, data_in, bit_out_reg,
	input wire logic [IDX_W-1:0] cfg_byte_idx,
	input wire logic [2:0] cfg_bit_sel
);
	logic [3:0] n;
	logic t1, t2, t3;
	wire ok = n == 4'hF;
	wire rz = ok && shift_trig && !t1;
	wire q = bit_out_reg;
	always @(posedge core_clk) n <= rst_b ? n + {3'h0, !ok} : 4'h0;
	always @(posedge core_clk) {t3, t2, t1} <= {t2, t1, shift_trig};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	rst_out_a: assert property (disable iff (1'b0) !rst_b |=> !q) else $error("rst");
	init_clear_a: assert property ($rose(rst_b) && !retain_en |-> (!q)[*8]) else $error("clr");
	edge_only_a: assert property (ok && $changed(q) |-> t2 && !t3) else $error("chg");
	no_early_a: assert property (rz |=> $stable(q)) else $error("lat");
	shift_up_a: assert property (rz && !shift_dir && ~|cfg_bit_sel |-> ##2 q == $past(data_in, 2))
		else $error("up");
	shift_down_a: assert property (rz && shift_dir && &cfg_bit_sel |-> ##2 q == $past(data_in, 2))
		else $error("dn");
	fall_hold_a: assert property (ok && t1 && !shift_trig |=> ##1 $stable(q)) else $error("fall");
	idle_hold_a: assert property (ok && !t2 && !t1 && !shift_trig |=> $stable(q)) else $error("idle");
	cover property (rz && shift_dir);
	cover property ($rose(rst_b) && retain_en);
	cover property (ok && $changed(q));
endmodule // etsr_props
bind etsr_shift etsr_props #(.NUM_BYTES(NUM_BYTES), .IDX_W(IDX_W)) u_etsr_props (.*);
`default_nettype wire

// ---- testbench/etsr_drv.sv ----
// Purpose: Upstream logic block model
// Assumes: Drives 1 ns after the edge
// Notes: Data inverts once its hold ends
`default_nettype none
module etsr_drv (
	input wire logic core_clk,
	output var logic shift_trig, shift_dir, data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {shift_trig, shift_dir, data_in} = 3'h0;
	task automatic push(input logic d, x);
		@(posedge core_clk) #1 {shift_trig, shift_dir, data_in} = {1'b1, d, x};
		@(posedge core_clk) #1 {shift_trig, data_in} = {1'b0, ~x};
		repeat (2) @(posedge core_clk);
		#1;
	endtask
endmodule // etsr_drv
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: Bench for etsr_shift
// Assumes: Config taken after reset
// Notes: p walks a bit end to end
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("unexpected %0t bad out", $time); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst_b = 1'b0, retain_en = 1'b0;
	logic [1:0] cfg_byte_idx = 2'h0;
	logic [2:0] cfg_bit_sel = 3'h0;
	logic [9:0] p = 10'h2D3;
	wire shift_trig, shift_dir, data_in, bit_out_reg;
	int errors = 0, compares = 0;
	always #50 core_clk = ~core_clk;
	etsr_drv u_etsr_drv (.*);
	etsr_shift u_etsr_shift (.*);
	task automatic boot(input logic [1:0] b, input logic [2:0] s, input logic r);
		{cfg_byte_idx, cfg_bit_sel, retain_en, rst_b} = {b, s, r, 1'b0};
		repeat (4) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
	endtask
	task automatic walk(input logic d);
		for (int i = 0; i < 10; i++) begin
			u_etsr_drv.push(d, p[i]);
			if (i > 6) `CHK(bit_out_reg, p[i-7])
		end
	endtask
	task automatic t_up;
		boot(2'h2, 3'h7, 1'b0);
		`CHK(bit_out_reg, 1'b0)
		cfg_byte_idx = 2'h0;
		walk(1'b0);
		u_etsr_drv.push(1'b1, 1'b1);
		`CHK(bit_out_reg, 1'b1)
		$display("t_up done");
	endtask
	task automatic t_down;
		boot(2'h0, 3'h0, 1'b0);
		walk(1'b1);
		u_etsr_drv.push(1'b0, 1'b1);
		`CHK(bit_out_reg, 1'b1)
		u_etsr_drv.push(1'b1, 1'b0);
		`CHK(bit_out_reg, p[2])
		$display("t_down done");
	endtask
	task automatic t_ret;
		u_etsr_drv.push(1'b0, 1'b1);
		boot(2'h0, 3'h0, 1'b1);
		`CHK(bit_out_reg, 1'b1)
		boot(2'h0, 3'h0, 1'b0);
		`CHK(bit_out_reg, 1'b0)
		$display("t_ret done");
	endtask
	task automatic results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		t_up;
		t_down;
		t_ret;
		results;
	end
endmodule // tb
`default_nettype wire
